//--- src/t2c_timer.sv
// Timer two: control register, counter, reload, capture and interrupt request
`timescale 1ns/1ps
`include "t2c_map.svh"

// Notes on behaviour
// - High overflow flag sets when the upper count byte overflows from FF and reloads.
// - In sixteen-bit mode the high flag sets when the full count overflows from FFFF.
// - With timer interrupts enabled, a set high flag requests an interrupt.
// - Flags are never cleared by hardware; software clears them by writing.
// - Low overflow flag sets whenever the low byte wraps, in every mode.
// - Low-byte enable plus timer enable makes low overflows request interrupts.
// - With capture enabled in sixteen-bit mode, comparator rising edges copy the count into reload.
// - With timer interrupts enabled, each capture event requests an interrupt.
// - Bit 3 selects one sixteen-bit counter or two eight-bit counters.
// - Bit 2 runs the counter when one and halts it when zero.
// - In split mode run gates only the high byte; the low byte always counts.
// - Control bit 1 reads zero and ignores writes.
// - External select picks system clock over 12 or external oscillator over 8.
// - The external oscillator is synchronised before advancing the counter.
// - In split mode external select serves both bytes; per-byte selects override.
// - Control sits at 0xC8 on every page and is bit addressable.
// - Sixteen-bit overflow loads the reload pair into the counter.
// - In split mode each byte reloads from its own reload byte.
// - A per-byte system clock select of one ticks that byte every clock, except the high-byte select in sixteen-bit mode.
module t2c_timer
   import t2c_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Special function register byte access
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_page,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   // Special function register single-bit access
   input  wire logic [7:0]  bit_addr,
   input  wire logic        bit_wr,
   input  wire logic        bit_wdata,
   // Clock selects and interrupt enable held elsewhere in the core
   input  wire logic        high_byte_system_clock_source_select,
   input  wire logic        low_byte_system_clock_source_select,
   input  wire logic        timer_irq_enable,
   // Asynchronous sources
   input  wire logic        external_oscillator,
   input  wire logic        analog_comparator_output,
   // Interrupt request
   output logic             timer_irq
);

   // Control register and counter state
   logic        high_overflow_flag;
   logic        low_overflow_flag;
   logic        low_byte_irq_enable;
   logic        comparator_capture_enable;
   logic        split_mode_select;
   logic        run_control;
   logic        external_clock_select;
   logic [7:0]  count_low_byte;
   logic [7:0]  count_high_byte;
   logic [7:0]  reload_low_byte;
   logic [7:0]  reload_high_byte;

   // Synchronisers and tick generation
   logic [1:0]  osc_sync;
   logic        osc_last;
   logic [2:0]  osc_div;
   logic [1:0]  cmp_sync;
   logic        cmp_last;
   logic [3:0]  sys_div;
   logic        ext_tick;
   logic        div_tick;
   logic        osc_rise;
   logic        cmp_rise;

   // Mode and tick sources
   t2c_mode_type   mode;
   t2c_source_type low_source;
   t2c_source_type high_source;
   logic           low_tick;
   logic           high_tick;

   // Decoded accesses
   wire page_timer = (sfr_page == `T2C_PAGE_TIMER);
   wire ctl_byte_wr = sfr_wr && (sfr_addr == `T2C_ADDR_CONTROL);
   wire ctl_bit_wr = bit_wr && (bit_addr[7:3] == 5'(`T2C_ADDR_CONTROL >> 3));
   wire rll_wr = sfr_wr && page_timer && (sfr_addr == `T2C_ADDR_RELOAD_LOW);
   wire rlh_wr = sfr_wr && page_timer && (sfr_addr == `T2C_ADDR_RELOAD_HIGH);
   wire cnl_wr = sfr_wr && page_timer && (sfr_addr == `T2C_ADDR_COUNT_LOW);
   wire cnh_wr = sfr_wr && page_timer && (sfr_addr == `T2C_ADDR_COUNT_HIGH);

   // Control register view and write data, byte or single bit
   wire [7:0] control_value =
   {
      high_overflow_flag,
      low_overflow_flag,
      low_byte_irq_enable,
      comparator_capture_enable,
      split_mode_select,
      run_control,
      1'b0,
      external_clock_select
   };
   logic [7:0] bit_merge;
   always_comb
   begin
      bit_merge = control_value;
      bit_merge[bit_addr[2:0]] = bit_wdata;
   end
   wire       ctl_wr = ctl_byte_wr || ctl_bit_wr;
   wire [7:0] ctl_wdata = ctl_bit_wr ? bit_merge : sfr_wdata;

   // External oscillator: two flip-flops, rising edge, then divide by eight
   assign osc_rise = osc_sync[1] && !osc_last;
   assign ext_tick = osc_rise && (osc_div == 3'(`T2C_EXTCLK_DIVISOR - 1));
   assign div_tick = (sys_div == 4'(`T2C_SYSTEM_CLOCK_SOURCE_DIVISOR - 1));
   assign cmp_rise = cmp_sync[1] && !cmp_last;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         osc_sync <= 2'h0;
         osc_last <= 1'b0;
         osc_div  <= 3'h0;
         cmp_sync <= 2'h0;
         cmp_last <= 1'b0;
         sys_div  <= 4'h0;
      end
      else
      begin
         osc_sync <= {osc_sync[0], external_oscillator};
         osc_last <= osc_sync[1];
         cmp_sync <= {cmp_sync[0], analog_comparator_output};
         cmp_last <= cmp_sync[1];
         if (osc_rise)
            osc_div <= ext_tick ? 3'h0 : osc_div + 3'h1;
         sys_div <= div_tick ? 4'h0 : sys_div + 4'h1;
      end
   end

   // Tick source per byte
   assign mode = split_mode_select ? t2c_mode_split : t2c_mode_sixteen;
   assign low_source = low_byte_system_clock_source_select ? t2c_src_system_clock_source :
                       external_clock_select  ? t2c_src_external : t2c_src_system_clock_source_div;
   assign high_source = high_byte_system_clock_source_select ? t2c_src_system_clock_source :
                        external_clock_select   ? t2c_src_external : t2c_src_system_clock_source_div;

   function automatic logic source_tick(input t2c_source_type src,
                                        input logic ext,
                                        input logic div);
      logic t;
      t = 1'b0;
      case (src)
         t2c_src_system_clock_source:     t = 1'b1;
         t2c_src_system_clock_source_div: t = div;
         t2c_src_external:   t = ext;
         default:            t = 1'b0;
      endcase
      return t;
   endfunction

   assign low_tick = source_tick(low_source, ext_tick, div_tick);
   assign high_tick = source_tick(high_source, ext_tick, div_tick);

   // Counting: sixteen-bit mode uses the low byte's source for the whole count
   wire low_step = (mode == t2c_mode_split) ? low_tick
                                            : (run_control && low_tick);
   wire high_step = (mode == t2c_mode_split) ? (run_control && high_tick)
                                             : (low_step && count_low_byte == `T2C_BYTE_MAX);
   wire low_wrap = low_step && (count_low_byte == `T2C_BYTE_MAX);
   wire high_wrap = high_step && (count_high_byte == `T2C_BYTE_MAX);
   wire capture = comparator_capture_enable && (mode == t2c_mode_sixteen) && cmp_rise;

   logic [7:0] next_count_low;
   logic [7:0] next_count_high;
   always_comb
   begin
      next_count_low = count_low_byte;
      next_count_high = count_high_byte;
      if (mode == t2c_mode_split)
      begin
         if (low_wrap)
            next_count_low = reload_low_byte;
         else if (low_step)
            next_count_low = count_low_byte + 8'h01;
         if (high_wrap)
            next_count_high = reload_high_byte;
         else if (high_step)
            next_count_high = count_high_byte + 8'h01;
      end
      else if (high_wrap)
      begin
         next_count_low = reload_low_byte;
         next_count_high = reload_high_byte;
      end
      else if (low_step)
      begin
         next_count_low = count_low_byte + 8'h01;
         if (high_step)
            next_count_high = count_high_byte + 8'h01;
      end
      if (cnl_wr)
         next_count_low = sfr_wdata;
      if (cnh_wr)
         next_count_high = sfr_wdata;
   end

   // Flag update: a hardware set outranks any software write
   wire set_high = high_wrap || capture;
   wire next_high_flag = set_high ||
                         (ctl_wr ? ctl_wdata[`T2C_BIT_HIGH_FLAG] : high_overflow_flag);
   wire next_low_flag = low_wrap ||
                        (ctl_wr ? ctl_wdata[`T2C_BIT_LOW_FLAG] : low_overflow_flag);

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         high_overflow_flag        <= 1'b0;
         low_overflow_flag         <= 1'b0;
         low_byte_irq_enable       <= 1'b0;
         comparator_capture_enable <= 1'b0;
         split_mode_select         <= 1'b0;
         run_control               <= 1'b0;
         external_clock_select     <= 1'b0;
      end
      else
      begin
         high_overflow_flag <= next_high_flag;
         low_overflow_flag  <= next_low_flag;
         if (ctl_wr)
         begin
            low_byte_irq_enable       <= ctl_wdata[`T2C_BIT_LOW_IRQ_EN];
            comparator_capture_enable <= ctl_wdata[`T2C_BIT_CAPTURE_EN];
            split_mode_select         <= ctl_wdata[`T2C_BIT_SPLIT];
            run_control               <= ctl_wdata[`T2C_BIT_RUN];
            external_clock_select     <= ctl_wdata[`T2C_BIT_EXT_CLOCK];
         end
      end
   end

   // Counter and reload bytes; a capture loads the reload pair from the count
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         count_low_byte   <= `T2C_BYTE_RESET;
         count_high_byte  <= `T2C_BYTE_RESET;
         reload_low_byte  <= `T2C_BYTE_RESET;
         reload_high_byte <= `T2C_BYTE_RESET;
      end
      else
      begin
         count_low_byte  <= next_count_low;
         count_high_byte <= next_count_high;
         if (rll_wr)
            reload_low_byte <= sfr_wdata;
         else if (capture)
            reload_low_byte <= count_low_byte;
         if (rlh_wr)
            reload_high_byte <= sfr_wdata;
         else if (capture)
            reload_high_byte <= count_high_byte;
      end
   end

   // Read data, registered one clock after the read strobe
   wire [7:0] read_mux =
      (sfr_addr == `T2C_ADDR_CONTROL)                    ? control_value :
      (page_timer && sfr_addr == `T2C_ADDR_RELOAD_LOW)  ? reload_low_byte :
      (page_timer && sfr_addr == `T2C_ADDR_RELOAD_HIGH) ? reload_high_byte :
      (page_timer && sfr_addr == `T2C_ADDR_COUNT_LOW)   ? count_low_byte :
      (page_timer && sfr_addr == `T2C_ADDR_COUNT_HIGH)  ? count_high_byte :
                                                          `T2C_BYTE_ZERO;

   always_ff @(posedge mclk)
   begin
      if (reset)
         sfr_rdata <= `T2C_BYTE_ZERO;
      else if (sfr_rd)
         sfr_rdata <= read_mux;
   end

   // Interrupt request follows the high flag, and the low flag when low-byte enable is set, while timer interrupts are enabled
   assign timer_irq = timer_irq_enable &&
                      (high_overflow_flag ||
                       (low_byte_irq_enable && low_overflow_flag));

endmodule

//--- src/t2c_map.svh
// Register addresses, bit positions, reset values and tick divisors of the timer block
`ifndef T2C_MAP_SVH
`define T2C_MAP_SVH

`define T2C_ADDR_CONTROL      8'hC8
`define T2C_ADDR_RELOAD_LOW   8'hCA
`define T2C_ADDR_RELOAD_HIGH  8'hCB
`define T2C_ADDR_COUNT_LOW    8'hCC
`define T2C_ADDR_COUNT_HIGH   8'hCD
`define T2C_PAGE_TIMER        8'h00

`define T2C_BIT_HIGH_FLAG     7
`define T2C_BIT_LOW_FLAG      6
`define T2C_BIT_LOW_IRQ_EN    5
`define T2C_BIT_CAPTURE_EN    4
`define T2C_BIT_SPLIT         3
`define T2C_BIT_RUN           2
`define T2C_BIT_UNUSED        1
`define T2C_BIT_EXT_CLOCK     0

`define T2C_CONTROL_RESET     8'h00
`define T2C_BYTE_RESET        8'h00
`define T2C_BYTE_MAX          8'hFF
`define T2C_BYTE_ZERO         8'h00

`define T2C_SYSTEM_CLOCK_SOURCE_DIVISOR    12
`define T2C_EXTCLK_DIVISOR    8

`endif

//--- src/t2c_pkg.sv
// Types shared by the timer control block
package t2c_pkg;

   typedef enum logic
   {
      t2c_mode_sixteen,
      t2c_mode_split
   } t2c_mode_type;

   typedef enum logic [1:0]
   {
      t2c_src_system_clock_source,
      t2c_src_system_clock_source_div,
      t2c_src_external
   } t2c_source_type;

endpackage

//--- testbench/t2c_cpu_model.sv
// Processor core model driving the timer's register bus
`timescale 1ns/1ps
module t2c_cpu_model (
   // Clock and read data
   input  wire logic       mclk,
   input  wire logic [7:0] sfr_rdata,
   // Register bus
   output logic      [7:0] sfr_addr,
   output logic      [7:0] sfr_page,
   output logic            sfr_wr,
   output logic            sfr_rd,
   output logic      [7:0] sfr_wdata,
   output logic      [7:0] bit_addr,
   output logic            bit_wr,
   output logic            bit_wdata
);
   initial {sfr_addr, sfr_page, sfr_wr, sfr_rd, sfr_wdata, bit_addr, bit_wr, bit_wdata} = '0;
   // Flags are cleared only by these explicit writes
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] pg = 8'h00);
      @(negedge mclk);
      {sfr_addr, sfr_wdata, sfr_page, sfr_wr} = {a, d, pg, 1'b1};
      @(negedge mclk);
      {sfr_wr, sfr_wdata} = {1'b0, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      {sfr_addr, sfr_rd} = {a, 1'b1};
      @(negedge mclk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask
   task automatic bw(input logic [7:0] a, input logic v);
      @(negedge mclk);
      {bit_addr, bit_wdata, bit_wr} = {a, v, 1'b1};
      @(negedge mclk);
      {bit_wr, bit_wdata} = {1'b0, ~v};
   endtask
endmodule

//--- testbench/t2c_timer_props.sv
// Port checker of the timer control block
`timescale 1ns/1ps
module t2c_timer_props (
   // Clock, reset and bus
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] bit_addr,
   input wire logic       bit_wr,
   input wire logic       bit_wdata,
   // Core levels, pins and request
   input wire logic       high_byte_system_clock_source_select,
   input wire logic       low_byte_system_clock_source_select,
   input wire logic       timer_irq_enable,
   input wire logic       external_oscillator,
   input wire logic       analog_comparator_output,
   input wire logic       timer_irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   logic ctl_wr;
   logic byte_ctl;
   assign byte_ctl = sfr_wr && sfr_addr == 8'hC8 && !bit_wr;
   assign ctl_wr = (sfr_wr && sfr_addr == 8'hC8) || (bit_wr && bit_addr[7:3] == 5'h19);
   property p_irq_gate; !timer_irq_enable |-> !timer_irq; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
   property p_unused; sfr_rd && sfr_addr == 8'hC8 |=> !sfr_rdata[1]; endproperty
   a_unused: assert property (p_unused) else $error("unused bit reads one");
   property p_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_page; sfr_rd && sfr_addr == 8'hCC && sfr_page != 8'h00 |=> sfr_rdata == 8'h00;
   endproperty
   a_page: assert property (p_page) else $error("count seen off page");
   property p_sticky; timer_irq && timer_irq_enable && !ctl_wr |=> timer_irq || !timer_irq_enable;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag cleared alone");
   property p_set_high; byte_ctl && sfr_wdata[7] |=> timer_irq || !timer_irq_enable; endproperty
   a_set_high: assert property (p_set_high) else $error("high flag no request");
   property p_low_irq; byte_ctl && sfr_wdata[6:5] == 2'b11 |=> timer_irq || !timer_irq_enable;
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("low flag no request");
   property p_readback; byte_ctl ##1 !ctl_wr ##1 (sfr_rd && sfr_addr == 8'hC8 && !ctl_wr)
      |=> (sfr_rdata & 8'h3D) == ($past(sfr_wdata, 3) & 8'h3D); endproperty
   a_readback: assert property (p_readback) else $error("control readback");
   c_irq: cover property (timer_irq);
   c_page: cover property (sfr_rd && sfr_page != 8'h00);
   c_bit: cover property (bit_wr ##1 sfr_rd);
endmodule
bind t2c_timer t2c_timer_props u_props (.mclk, .reset, .sfr_addr, .sfr_page, .sfr_wr,
   .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_addr, .bit_wr, .bit_wdata, .high_byte_system_clock_source_select,
   .low_byte_system_clock_source_select, .timer_irq_enable, .external_oscillator,
   .analog_comparator_output, .timer_irq);

//--- testbench/tb.sv
// Self-checking bench of the timer control block
`timescale 1ns/1ps
module tb;
   logic       mclk = 1'b0;
   logic       reset = 1'b1;
   logic       hi_sel = 1'b0;
   logic       lo_sel = 1'b0;
   logic       irq_en = 1'b0;
   logic       osc = 1'b0;
   logic       cmp = 1'b0;
   logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, bit_addr, rv, expv;
   logic       sfr_wr, sfr_rd, bit_wr, bit_wdata, timer_irq;
   int         num_errors = 0;
   int         total_checks = 0;
   always #50 mclk = ~mclk;
   t2c_cpu_model cpu (.mclk(mclk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
      .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata));
   t2c_timer uut (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
      .high_byte_system_clock_source_select(hi_sel), .low_byte_system_clock_source_select(lo_sel),
      .timer_irq_enable(irq_en), .external_oscillator(osc),
      .analog_comparator_output(cmp), .timer_irq(timer_irq));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [7:0] ctl_exp(input logic [7:0] d);
      return d & 8'hFD;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   initial
   begin
      #(3000 * 100);
      num_errors++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(32'h0C1C));
      cyc(5);
      reset = 1'b0;
      for (int a = 8'hC8; a <= 8'hCD; a++)
      begin
         cpu.rd(8'(a), rv);
         check(rv, 8'h00);
      end
      $display("test reset done");
      repeat (8)
      begin
         expv = 8'($urandom);
         cpu.wr(8'hC8, expv, 8'($urandom));
         cpu.rd(8'hC8, rv);
         check(rv, ctl_exp(expv));
      end
      cpu.wr(8'hC8, 8'h00);
      expv = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         expv[i] = 1'($urandom);
         cpu.bw(8'(8'hC8 + i), expv[i]);
         cpu.rd(8'hC8, rv);
         check(rv, ctl_exp(expv));
      end
      $display("test control done");
      lo_sel = 1'b1;
      cpu.wr(8'hC8, 8'h00);
      cpu.wr(8'hCA, 8'h34);
      cpu.wr(8'hCB, 8'h12);
      cpu.wr(8'hCC, 8'hFE);
      cpu.wr(8'hCD, 8'hFF);
      cpu.wr(8'hC8, 8'h04);
      cyc(6);
      cpu.bw(8'hCA, 1'b0);
      cpu.rd(8'hC8, rv);
      check(rv, 8'hC0);
      cpu.rd(8'hCD, rv);
      check(rv, 8'h12);
      irq_en = 1'b1;
      cyc(1);
      check({7'h00, timer_irq}, 8'h01);
      cpu.bw(8'hCF, 1'b0);
      check({7'h00, timer_irq}, 8'h00);
      $display("test sixteen done");
      hi_sel = 1'b1;
      cpu.wr(8'hCA, 8'h80);
      cpu.wr(8'hCD, 8'hF0);
      cpu.wr(8'hCC, 8'hFE);
      cpu.wr(8'hC8, 8'h28);
      cyc(4);
      check({7'h00, timer_irq}, 8'h01);
      cpu.rd(8'hC8, rv);
      check(rv, 8'h68);
      cpu.rd(8'hCD, rv);
      check(rv, 8'hF0);
      cpu.rd(8'hCC, rv);
      check(rv & 8'h80, 8'h80);
      cpu.wr(8'hC8, 8'h0C);
      cyc(20);
      cpu.rd(8'hC8, rv);
      check(rv, 8'h8C);
      $display("test split done");
      {hi_sel, lo_sel} = 2'b00;
      for (int k = 0; k < 2; k++)
      begin
         cpu.wr(8'hC8, 8'h00);
         cpu.wr(8'hCC, 8'h00);
         cpu.wr(8'hCD, 8'h00);
         cpu.wr(8'hC8, 8'(8'h04 + k));
         repeat (k ? 160 : 60)
         begin
            osc = ~osc;
            cyc(2);
         end
         cpu.wr(8'hC8, 8'h00);
         cpu.rd(8'hCC, rv);
         check(8'(rv inside {8'h09, 8'h0A, 8'h0B}), 8'h01);
      end
      $display("test source done");
      lo_sel = 1'b1;
      cpu.wr(8'hCD, 8'h55);
      cpu.wr(8'hC8, 8'h14);
      cyc(3);
      cmp = 1'b1;
      cyc(6);
      cpu.bw(8'hCA, 1'b0);
      cpu.rd(8'hCB, rv);
      check(rv, 8'h55);
      cpu.rd(8'hC8, rv);
      check(rv, 8'h90);
      check({7'h00, timer_irq}, 8'h01);
      $display("test capture done");
      cpu.wr(8'hC8, 8'h08);
      cpu.wr(8'hCC, 8'hFE);
      cpu.wr(8'hC8, 8'h08);
      cpu.rd(8'hC8, rv);
      check(rv, 8'h48);
      cpu.wr(8'hC8, 8'hE0);
      check({7'h00, timer_irq}, 8'h01);
      cpu.rd(8'hC8, rv);
      check(rv, 8'hE0);
      cpu.wr(8'hCD, 8'h77, 8'h0F);
      cpu.rd(8'hCC, rv);
      check(rv, 8'h00);
      cpu.wr(8'hC8, 8'h00);
      check({7'h00, timer_irq}, 8'h00);
      cpu.rd(8'hCD, rv);
      check(rv, 8'h55);
      $display("test flags done");
      give_verdict();
   end
endmodule
